/* verilog/pps_params.svh */
// constants for the pattern sequencer: offsets, fields, reset values, limits
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
// register byte addresses
`define PPS_ADR_CTRL 6'h00
`define PPS_ADR_LEN 6'h04
`define PPS_ADR_PAGE 6'h08
`define PPS_ADR_PDATA 6'h0C
`define PPS_ADR_BITWR 6'h10
`define PPS_ADR_CMD 6'h14
`define PPS_ADR_REPA 6'h18
`define PPS_ADR_REPB 6'h1C
`define PPS_ADR_STAT 6'h20
// control fields
`define PPS_CTRL_RUN 2
`define PPS_CTRL_EDITB 3
`define PPS_CTRL_EXT 4
`define PPS_CTRL_ERREN 5
`define PPS_CTRL_ERRSGL 6
// command fields
`define PPS_CMD_POL 0
`define PPS_CMD_PGPRE 1
`define PPS_CMD_ALLPRE 2
`define PPS_CMD_VAL 3
`define PPS_CMD_PROT 4
`define PPS_CMD_ERRTRIG 5
// reset values
`define PPS_LEN_RST 23'h000080
`define PPS_REP_RST 16'h0001
`define PPS_LFSR_RST 7'h7F
// length limits
`define PPS_ALT_MIN 23'h000080
`define PPS_ALT_MAX 23'h400000
`define PPS_SGL_MIN 23'h000002
`define PPS_SGL_S1_MAX 23'h00FFF6
`define PPS_SGL_S2_MIN 23'h010000
`define PPS_SGL_MAX 23'h01FFC4
`define PPS_ZS_MIN 23'h000001
`define PPS_ZS_MAX 23'h00007F
// pseudorandom periods, last bit index
`define PPS_PRBS_LAST 23'h00007E
`define PPS_ZS_LAST 23'h00007F
// error rate periods in bits
`define PPS_ERR_P0 24'h0003E8
`define PPS_ERR_P1 24'h002710
`define PPS_ERR_P2 24'h0186A0
`define PPS_ERR_P3 24'h0F4240
`define PPS_ERR_P4 24'h989680
`endif

/* verilog/pps_pkg.sv */
// types shared by the pattern sequencer modules
package pps_pkg;
  typedef logic [5:0] pps_addr_t;
  typedef logic [31:0] pps_word_t;
  typedef logic [22:0] pps_len_t;
  typedef logic [18:0] pps_page_t;
  typedef enum logic [1:0] {
    PPS_MODE_ALT = 2'h0,
    PPS_MODE_DATA = 2'h1,
    PPS_MODE_ZS = 2'h2,
    PPS_MODE_PRBS = 2'h3
  } pps_mode_e;
  typedef enum logic [1:0] {
    PPS_ST_A = 2'b01,
    PPS_ST_B = 2'b10
  } pps_ab_e;
endpackage : pps_pkg

/* verilog/pps_buf.sv */
// two-entry output buffer: registered output stage plus one skid slot
module pps_buf (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic in_data_in,
  output logic in_ready_out,
  // draining side
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic out_data_out
);
  logic skid_v_q;
  logic skid_d_q;
  wire drain = out_ready_in | ~out_valid_out;
  // ready is a flop, so the filler never sees a combinational path
  assign in_ready_out = ~skid_v_q;
  // output stage refills from the skid slot first to keep order
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= 1'b0;
      skid_v_q <= 1'b0;
      skid_d_q <= 1'b0;
    end else if (drain) begin
      out_valid_out <= skid_v_q | in_valid_in;
      out_data_out <= skid_v_q ? skid_d_q : in_data_in;
      skid_v_q <= 1'b0;
    end else if (in_valid_in & ~skid_v_q) begin
      skid_v_q <= 1'b1;
      skid_d_q <= in_data_in;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_buf_hold: assert property (out_valid_out && !out_ready_in |=>
    out_valid_out && $stable(out_data_out)) else $error("stalled word changed");
  cov_buf_full: cover property (skid_v_q && out_valid_out && !out_ready_in);
endmodule : pps_buf

/* verilog/pps_err.sv */
// error injector: periodic flips at a chosen rate or one flip per trigger
`include "pps_params.svh"
module pps_err (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control
  input wire logic en_in,
  input wire logic single_in,
  input wire logic [2:0] rate_in,
  input wire logic trig_in,
  // bit stream
  input wire logic step_in,
  output logic flip_out
);
  logic [23:0] cnt_q;
  logic pend_q;
  // rate code to period; codes above four use the slowest rate
  function automatic logic [23:0] period(input logic [2:0] r);
    case (r)
      3'h0: period = `PPS_ERR_P0;
      3'h1: period = `PPS_ERR_P1;
      3'h2: period = `PPS_ERR_P2;
      3'h3: period = `PPS_ERR_P3;
      default: period = `PPS_ERR_P4;
    endcase
  endfunction : period
  assign flip_out = en_in & (single_in ? pend_q : (cnt_q == 24'h000000));
  // a trigger in the same cycle as the consuming bit stays pending
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 24'h000000;
      pend_q <= 1'b0;
    end else begin
      pend_q <= (trig_in & en_in & single_in) | (pend_q & ~(step_in & flip_out));
      if (step_in) begin
        cnt_q <= (cnt_q == 24'h000000) ? period(rate_in) - 24'h000001 : cnt_q - 24'h000001;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_single_once: assert property (step_in && flip_out && single_in && !trig_in
    |=> !pend_q) else $error("single error injected twice");
endmodule : pps_err

/* verilog/pps_top.sv */
// pattern sequencer core: page memory, playback, presets, polarity, errors
//
// Contract
// - each polarity command flips output logic, positive then negative and back.
// - two-pattern mode keeps patterns A and B, each with its own repeat count.
// - one length register serves both A and B.
// - two-pattern length runs 128 to 4194304 bits in steps of 128.
// - single length steps by 1 up to 65526, by 2 from 65536 to 131012.
// - pages of 16 bits, page index 1 up to ceiling of length over 16.
// - page preset fills the selected page only with the chosen value.
// - whole preset works only with protect set, fills the pattern length.
// - bit 1 of page 1 is sent first in every repetition.
// - stored one is high under positive logic; single bits writable.
// - external select picks A or B and disables repeat counts.
// - single pattern repeats endlessly without gaps.
// - in zero substitution the length sets the zero run inside the pseudorandom stream.
// - error injection switchable, rate selectable, one error per single trigger.
//
// The register offsets and strobed register access were chosen for this implementation.
`include "pps_params.svh"
module pps_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // register port
  input wire pps_pkg::pps_addr_t reg_addr_in,
  input wire pps_pkg::pps_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output pps_pkg::pps_word_t reg_rdata_out,
  // external pattern A/B select
  input wire logic ext_ab_sel_in,
  // serial pattern to the receiver
  input wire logic ser_ready_in,
  output logic ser_valid_out,
  output logic ser_data_out,
  output logic play_b_out
);
  import pps_pkg::*;

  // legal length for the mode in force; out-of-range settings clamp to the limits, others round down to a step, the single-mode gap goes up to 65536
  function automatic pps_len_t legal_len(input pps_mode_e m, input pps_len_t v);
    pps_len_t r;
    r = v;
    case (m)
      PPS_MODE_ALT: begin
        if (v < `PPS_ALT_MIN) r = `PPS_ALT_MIN;
        else if (v > `PPS_ALT_MAX) r = `PPS_ALT_MAX;
        else r = {v[22:7], 7'h00};
      end
      PPS_MODE_DATA: begin
        if (v < `PPS_SGL_MIN) r = `PPS_SGL_MIN;
        else if (v > `PPS_SGL_MAX) r = `PPS_SGL_MAX;
        else if (v > `PPS_SGL_S1_MAX && v < `PPS_SGL_S2_MIN) r = `PPS_SGL_S2_MIN;
        else if (v >= `PPS_SGL_S2_MIN) r = {v[22:1], 1'b0};
      end
      default: begin
        if (v < `PPS_ZS_MIN) r = `PPS_ZS_MIN;
        else if (v > `PPS_ZS_MAX) r = `PPS_ZS_MAX;
      end
    endcase
    return r;
  endfunction : legal_len

  // number of 16-bit pages covering a length
  // the same count bounds the page register and the whole preset walk
  function automatic pps_page_t page_cnt(input pps_len_t l);
    return pps_page_t'(l[22:4]) + pps_page_t'(|l[3:0]);
  endfunction : page_cnt

  // settings
  pps_mode_e mode_q;
  logic run_q;
  logic edit_b_q;
  logic ext_q;
  logic err_en_q;
  logic err_sgl_q;
  logic [2:0] rate_q;
  pps_len_t len_q;
  pps_page_t page_q;
  logic [15:0] rep_a_q;
  logic [15:0] rep_b_q;
  logic pol_q;
  // preset engine
  logic busy_q;
  logic pre_val_q;
  pps_page_t pre_pg_q;
  // playback
  pps_ab_e st_q;
  pps_len_t bit_q;
  logic [15:0] rep_q;
  logic [6:0] lfsr_q;
  pps_word_t rdata_q;
  // pattern store, pattern select above page index; no reset on the array
  logic [15:0] mem_q [0:16383];

  // register decode
  wire wr_ctrl = reg_wr_in & (reg_addr_in == `PPS_ADR_CTRL);
  wire wr_len = reg_wr_in & (reg_addr_in == `PPS_ADR_LEN);
  wire wr_page = reg_wr_in & (reg_addr_in == `PPS_ADR_PAGE);
  wire wr_pdata = reg_wr_in & (reg_addr_in == `PPS_ADR_PDATA);
  wire wr_bit = reg_wr_in & (reg_addr_in == `PPS_ADR_BITWR);
  wire wr_cmd = reg_wr_in & (reg_addr_in == `PPS_ADR_CMD);
  wire wr_repa = reg_wr_in & (reg_addr_in == `PPS_ADR_REPA);
  wire wr_repb = reg_wr_in & (reg_addr_in == `PPS_ADR_REPB);
  wire cmd_pol = wr_cmd & reg_wdata_in[`PPS_CMD_POL];
  wire cmd_pgpre = wr_cmd & reg_wdata_in[`PPS_CMD_PGPRE];
  wire cmd_val = reg_wdata_in[`PPS_CMD_VAL];
  wire cmd_all = wr_cmd & reg_wdata_in[`PPS_CMD_ALLPRE];
  wire cmd_prot = reg_wdata_in[`PPS_CMD_PROT];
  wire cmd_trig = wr_cmd & reg_wdata_in[`PPS_CMD_ERRTRIG];

  // length and paging seen by every consumer
  wire pps_len_t len_eff = legal_len(mode_q, len_q);
  wire pps_page_t page_max = page_cnt(len_eff);
  wire pps_page_t page_wv = pps_page_t'(reg_wdata_in[18:0]);
  wire pps_page_t page_clamp = (page_wv == 19'h00000) ? 19'h00001 :
                               (page_wv > page_max) ? page_max : page_wv;
  wire pps_page_t pidx = page_q - 19'h00001;
  wire [13:0] edit_wa = {edit_b_q, pidx[12:0]};
  wire [15:0] edit_rd = mem_q[edit_wa];

  // playback decode
  wire is_pat = (mode_q == PPS_MODE_ALT) | (mode_q == PPS_MODE_DATA);
  wire is_zs = (mode_q == PPS_MODE_ZS);
  wire pps_len_t last_idx = is_pat ? len_eff - 23'h000001 :
                            is_zs ? `PPS_ZS_LAST : `PPS_PRBS_LAST;
  wire pat_last = (bit_q == last_idx);
  wire [13:0] play_a = {st_q == PPS_ST_B, bit_q[16:4]};
  wire [15:0] play_word = mem_q[play_a];
  wire pat_bit = play_word[bit_q[3:0]];
  wire zs_bit = (bit_q < len_eff) | pat_last ? 1'b0 : lfsr_q[6];
  wire src_bit = is_pat ? pat_bit : is_zs ? zs_bit : lfsr_q[6];
  wire [15:0] cur_rep = (st_q == PPS_ST_B) ? rep_b_q : rep_a_q;
  // a repeat count of zero plays once, the same as one
  wire rep_done = ({1'b0, rep_q} + 17'h00001) >= {1'b0, cur_rep};
  wire buf_ready;
  wire err_flip;
  wire gen_go = run_q & buf_ready;
  wire out_bit = src_bit ^ pol_q ^ err_flip;
  wire lfsr_go = gen_go & ~is_pat & ~(is_zs & pat_last);

  // next pattern at a repetition boundary
  pps_ab_e st_next;
  always_comb begin
    st_next = st_q;
    if (mode_q != PPS_MODE_ALT) st_next = PPS_ST_A;
    else if (ext_q) st_next = ext_ab_sel_in ? PPS_ST_B : PPS_ST_A;
    else if (rep_done) st_next = (st_q == PPS_ST_A) ? PPS_ST_B : PPS_ST_A;
  end

  // edits landing while a whole preset walks are lost, so software polls busy first
  // memory write port: preset engine first, then software edits
  logic mem_we;
  logic [13:0] mem_wa;
  logic [15:0] mem_wd;
  always_comb begin
    mem_we = 1'b1;
    mem_wa = edit_wa;
    mem_wd = reg_wdata_in[15:0];
    if (busy_q) begin
      mem_wa = {edit_b_q, pre_pg_q[12:0]};
      mem_wd = {16{pre_val_q}};
    end else if (cmd_pgpre) begin
      mem_wd = {16{cmd_val}};
    end else if (wr_bit) begin
      mem_wd = edit_rd;
      mem_wd[reg_wdata_in[3:0]] = reg_wdata_in[4];
    end else if (!wr_pdata) begin
      mem_we = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (mem_we) mem_q[mem_wa] <= mem_wd;
  end

  // software settings
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= PPS_MODE_DATA;
      run_q <= 1'b0;
      edit_b_q <= 1'b0;
      ext_q <= 1'b0;
      err_en_q <= 1'b0;
      err_sgl_q <= 1'b0;
      rate_q <= 3'h0;
    end else if (wr_ctrl) begin
      mode_q <= pps_mode_e'(reg_wdata_in[1:0]);
      run_q <= reg_wdata_in[`PPS_CTRL_RUN];
      edit_b_q <= reg_wdata_in[`PPS_CTRL_EDITB];
      ext_q <= reg_wdata_in[`PPS_CTRL_EXT];
      err_en_q <= reg_wdata_in[`PPS_CTRL_ERREN];
      err_sgl_q <= reg_wdata_in[`PPS_CTRL_ERRSGL];
      rate_q <= reg_wdata_in[10:8];
    end
  end

  // length, page and repeat counts; one length for both patterns
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      len_q <= `PPS_LEN_RST;
      page_q <= 19'h00001;
      rep_a_q <= `PPS_REP_RST;
      rep_b_q <= `PPS_REP_RST;
    end else begin
      if (wr_len) len_q <= reg_wdata_in[22:0];
      if (wr_page) page_q <= page_clamp;
      if (wr_repa) rep_a_q <= reg_wdata_in[15:0];
      if (wr_repb) rep_b_q <= reg_wdata_in[15:0];
    end
  end

  // polarity toggles once per command
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) pol_q <= 1'b0;
    else if (cmd_pol) pol_q <= ~pol_q;
  end

  // whole preset walks one page per cycle; without protect it is ignored
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_q <= 1'b0;
      pre_val_q <= 1'b0;
      pre_pg_q <= 19'h00000;
    end else if (busy_q) begin
      pre_pg_q <= pre_pg_q + 19'h00001;
      if (pre_pg_q == page_max - 19'h00001) busy_q <= 1'b0;
    end else if (cmd_all & cmd_prot) begin
      busy_q <= 1'b1;
      pre_val_q <= cmd_val;
      pre_pg_q <= 19'h00000;
    end
  end

  // playback pointer: wraps to the first bit with no idle cycle
  // clearing run parks the pointer at bit one of pattern A, so every start is clean
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_q <= 23'h000000;
      st_q <= PPS_ST_A;
      rep_q <= 16'h0000;
    end else if (!run_q) begin
      bit_q <= 23'h000000;
      st_q <= PPS_ST_A;
      rep_q <= 16'h0000;
    end else if (gen_go) begin
      bit_q <= pat_last ? 23'h000000 : bit_q + 23'h000001;
      if (pat_last) begin
        st_q <= st_next;
        rep_q <= (st_next != st_q || ext_q) ? 16'h0000 : rep_q + 16'h0001;
      end
    end
  end

  // pseudorandom source, x^7 + x^6 + 1; holds on the added zero bit
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) lfsr_q <= `PPS_LFSR_RST;
    else if (lfsr_go) lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end

  // read data stands only in the cycle after the strobe
  wire pps_word_t rd_ctrl = {21'h000000, rate_q, 1'b0, err_sgl_q, err_en_q, ext_q,
                             edit_b_q, run_q, mode_q};
  wire pps_word_t rd_stat = {1'b0, page_max, 9'h000, st_q == PPS_ST_B, busy_q, pol_q};
  wire pps_word_t rd_val =
    (reg_addr_in == `PPS_ADR_CTRL) ? rd_ctrl :
    (reg_addr_in == `PPS_ADR_LEN) ? {9'h000, len_eff} :
    (reg_addr_in == `PPS_ADR_PAGE) ? {13'h0000, page_q} :
    (reg_addr_in == `PPS_ADR_PDATA) ? {16'h0000, edit_rd} :
    (reg_addr_in == `PPS_ADR_REPA) ? {16'h0000, rep_a_q} :
    (reg_addr_in == `PPS_ADR_REPB) ? {16'h0000, rep_b_q} :
    (reg_addr_in == `PPS_ADR_STAT) ? rd_stat : 32'h00000000;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) rdata_q <= 32'h00000000;
    else rdata_q <= reg_rd_in ? rd_val : 32'h00000000;
  end
  assign reg_rdata_out = rdata_q;
  assign play_b_out = st_q[1];

  // error injection on the bit being handed to the buffer
  // the injector steps with the pointer, so its rate counts bits actually made
  pps_err u_err (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .en_in(err_en_q),
    .single_in(err_sgl_q),
    .rate_in(rate_q),
    .trig_in(cmd_trig),
    .step_in(gen_go),
    .flip_out(err_flip)
  );

  // two-entry buffer so a receiver stall never drops a bit
  // valid simply follows run; while the buffer is full the pointer waits instead
  pps_buf u_buf (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(run_q),
    .in_data_in(out_bit),
    .in_ready_out(buf_ready),
    .out_ready_in(ser_ready_in),
    .out_valid_out(ser_valid_out),
    .out_data_out(ser_data_out)
  );

  // checks run on the core clock and sleep through reset
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_pol_toggle: assert property (cmd_pol |=> pol_q != $past(pol_q))
    else $error("polarity did not toggle");
  chk_alt_len: assert property (mode_q == PPS_MODE_ALT |-> len_eff[6:0] == 7'h00 &&
    len_eff >= `PPS_ALT_MIN && len_eff <= `PPS_ALT_MAX) else $error("bad alt length");
  chk_sgl_len: assert property (mode_q == PPS_MODE_DATA |-> len_eff >= `PPS_SGL_MIN &&
    len_eff <= `PPS_SGL_MAX && (len_eff <= `PPS_SGL_S1_MAX || !len_eff[0]) &&
    !(len_eff > `PPS_SGL_S1_MAX && len_eff < `PPS_SGL_S2_MIN))
    else $error("bad single length");
  chk_page_range: assert property (wr_page |=> page_q >= 19'h00001 &&
    page_q <= $past(page_max)) else $error("page out of range");
  chk_wrap_head: assert property (gen_go && pat_last |=> bit_q == 23'h000000)
    else $error("pattern did not restart at bit one");
  chk_preset_guard: assert property (cmd_all && !cmd_prot && !busy_q |=> !busy_q)
    else $error("preset ran without protect");
  chk_ext_select: assert property (gen_go && pat_last && ext_q &&
    mode_q == PPS_MODE_ALT |=> st_q == ($past(ext_ab_sel_in) ? PPS_ST_B : PPS_ST_A))
    else $error("external select not followed");
  chk_alt_switch: assert property (gen_go && pat_last && !ext_q && mode_q == PPS_MODE_ALT
    && st_q == PPS_ST_A && rep_done |=> st_q == PPS_ST_B) else $error("A did not hand to B");
  chk_zs_zero: assert property (gen_go && is_zs && bit_q < len_eff |-> !src_bit)
    else $error("zero run broken");
  cov_alt_to_b: cover property (st_q == PPS_ST_A ##1 st_q == PPS_ST_B);
  cov_preset_done: cover property (busy_q ##1 !busy_q);
  cov_err_flip: cover property (gen_go && err_flip);
  chk_b_to_a: assert property (gen_go && pat_last && !ext_q && mode_q == PPS_MODE_ALT
    && st_q == PPS_ST_B && rep_done |=> st_q == PPS_ST_A) else $error("B did not hand to A");
  chk_page_fill: assert property (cmd_pgpre && !busy_q |=>
    mem_q[$past(edit_wa)] == {16{$past(cmd_val)}}) else $error("page preset missed");
  chk_bit_write: assert property (wr_bit && !busy_q |=>
    edit_rd[$past(reg_wdata_in[3:0])] == $past(reg_wdata_in[4])) else $error("bit lost");
  chk_run_restart: assert property (!run_q |=> bit_q == 23'h000000 && st_q == PPS_ST_A)
    else $error("stopped pointer not at bit one");
  cov_ext_b: cover property (ext_q && st_q == PPS_ST_B);
endmodule : pps_top

/* bench/pps_rx_model.sv */
// receiver model at the serial side: takes bits, stalls at random on request
module pps_rx_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // serial link
  input wire logic valid_in,
  input wire logic data_in,
  input wire logic stall_in,
  output logic ready_out,
  // accepted bit tap
  output logic take_out,
  output logic bit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready moves just after the edge; a slow receiver drops it about one cycle in three
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ready_out <= 1'h0;
    end else begin
      ready_out <= stall_in ? (($urandom % 3) != 0) : 1'h1;
    end
  end
  // a bit is taken only on an edge where valid and ready meet
  assign take_out = valid_in & ready_out;
  assign bit_out = data_in;
endmodule : pps_rx_model

/* bench/test_programmable_pattern_sequencer.sv */
// self-checking bench for the pattern sequencer core
`include "pps_params.svh"
module test_programmable_pattern_sequencer;
  import pps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, wr_s, rd_s, ext, stall, take, bitv, rdy, sv, sd, pb, pol, pbl;
  pps_addr_t adr;
  pps_word_t wd, rdat, d;
  logic [15:0] pg [3];
  logic got [$];
  int err_count, compares;
  pps_top u_pps_top (.core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(adr),
    .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdat),
    .ext_ab_sel_in(ext), .ser_ready_in(rdy), .ser_valid_out(sv), .ser_data_out(sd),
    .play_b_out(pb));
  pps_rx_model u_pps_rx_model (.clk_in(clk), .nrst_in(nrst), .valid_in(sv),
    .data_in(sd), .stall_in(stall), .ready_out(rdy), .take_out(take), .bit_out(bitv));
  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // every accepted bit is kept for later comparison
  always @(posedge clk) begin
    if (take === 1'h1) begin
      got.push_back(bitv);
    end
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input pps_word_t g, input pps_word_t e, input string m);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  // one-cycle strobes, changed just after the edge
  task automatic wr(input pps_addr_t a, input pps_word_t v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input pps_addr_t a, output pps_word_t v);
    @(posedge clk);
    adr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    @(negedge clk);
    v = rdat;
  endtask : rd
  task automatic rdchk(input pps_addr_t a, input pps_word_t e, input string m);
    pps_word_t v;
    rd(a, v);
    chk(v, e, m);
  endtask : rdchk
  task automatic wait_bits(input int n);
    for (int i = 0; i < n * 8 + 200; i++) begin
      if (got.size() >= n) return;
      @(posedge clk);
    end
    err_count++;
    $display("[FAIL] %0t serial stream stalled", $time);
    report_and_stop();
  endtask : wait_bits
  // preset busy is polled, never waited blind
  task automatic wait_idle();
    pps_word_t v;
    for (int i = 0; i < 40; i++) begin
      rd(`PPS_ADR_STAT, v);
      if (v[1] === 1'h0) return;
    end
    err_count++;
    $display("[FAIL] %0t preset never finished", $time);
    report_and_stop();
  endtask : wait_idle
  // run from bit 0, collect n bits, stop and let the buffer drain
  task automatic play(input pps_word_t c, input int n);
    got.delete();
    wr(`PPS_ADR_CTRL, c | 32'h4);
    wait_bits(n);
    @(negedge clk);
    pbl = pb;
    wr(`PPS_ADR_CTRL, c);
    repeat (30) @(posedge clk);
  endtask : play
  // kind 0: 40-bit page data, 1: A twice then B three times, 2: zeros, 3: ones
  function automatic logic exp_bit(input int k, input int i);
    int x;
    x = i % 40;
    case (k)
      0: return pg[x / 16][x % 16] ^ pol;
      1: return ((i / 128) % 5) < 2;
      default: return k == 3;
    endcase
  endfunction : exp_bit
  function automatic int cnt(input int lo, input int hi);
    int s;
    s = 0;
    for (int i = lo; i < hi && i < got.size(); i++) s += (got[i] !== 1'h0);
    return s;
  endfunction : cnt
  task automatic cmp(input int k, input int lo, input int hi, input string m);
    int bad;
    bad = 0;
    for (int i = lo; i < hi; i++) bad += (got[i] !== exp_bit(k, i));
    chk(bad, 0, m);
  endtask : cmp
  initial begin
    logic [1:0] lm [9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
    pps_word_t li [9] = '{32'h1, 32'h7, 32'hFFFA, 32'h10001, 32'h1FFC5, 32'hFFF6,
      32'hC8, 32'h500000, 32'h180};
    pps_word_t le [9] = '{32'h2, 32'h7, 32'h10000, 32'h10000, 32'h1FFC4, 32'hFFF6,
      32'h80, 32'h400000, 32'h180};
    {adr, wd, wr_s, rd_s, ext, stall, nrst, pol} = '0;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h7E59));
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    // reset values and an unmapped address
    rdchk(`PPS_ADR_LEN, 32'h80, "len reset");
    rdchk(`PPS_ADR_PAGE, 32'h1, "page reset");
    rdchk(`PPS_ADR_REPA, 32'h1, "rep a reset");
    rdchk(`PPS_ADR_REPB, 32'h1, "rep b reset");
    rdchk(`PPS_ADR_STAT, 32'h8000, "stat reset");
    rdchk(6'h3C, 32'h0, "unmapped read");
    // length steps and limits in both modes
    for (int i = 0; i < 9; i++) begin
      wr(`PPS_ADR_CTRL, {30'h0, lm[i]});
      wr(`PPS_ADR_LEN, li[i]);
      rdchk(`PPS_ADR_LEN, le[i], "length snap");
    end
    wr(`PPS_ADR_CTRL, 32'h8);
    wr(`PPS_ADR_LEN, 32'h100);
    wr(`PPS_ADR_CTRL, 32'h0);
    rdchk(`PPS_ADR_LEN, 32'h100, "shared length");
    // 40-bit pattern over three pages, the last one partial
    wr(`PPS_ADR_CTRL, 32'h1);
    wr(`PPS_ADR_LEN, 32'h28);
    rd(`PPS_ADR_STAT, d);
    chk({13'h0, d[30:12]}, 32'h3, "page count");
    wr(`PPS_ADR_PAGE, 32'h63);
    rdchk(`PPS_ADR_PAGE, 32'h3, "page clamp");
    for (int p = 0; p < 3; p++) begin
      pg[p] = 16'($urandom);
      wr(`PPS_ADR_PAGE, 32'(p + 1));
      wr(`PPS_ADR_PDATA, {16'h0, pg[p]});
    end
    wr(`PPS_ADR_BITWR, {27'h0, ~pg[2][4], 4'h4});
    pg[2][4] = ~pg[2][4];
    rdchk(`PPS_ADR_PDATA, {16'h0, pg[2]}, "bit write");
    wr(`PPS_ADR_PAGE, 32'h2);
    wr(`PPS_ADR_CMD, 32'hA);
    pg[1] = 16'hFFFF;
    rdchk(`PPS_ADR_PDATA, 32'hFFFF, "page preset");
    wr(`PPS_ADR_PAGE, 32'h1);
    rdchk(`PPS_ADR_PDATA, {16'h0, pg[0]}, "other page kept");
    stall = 1'h1;
    play(32'h1, 100);
    cmp(0, 0, 100, "data stream");
    // negative logic and back
    wr(`PPS_ADR_CMD, 32'h1);
    pol = 1'h1;
    rdchk(`PPS_ADR_STAT, 32'h3001, "negative logic");
    play(32'h1, 100);
    cmp(0, 0, 100, "inverted stream");
    wr(`PPS_ADR_CMD, 32'h1);
    pol = 1'h0;
    rdchk(`PPS_ADR_STAT, 32'h3000, "positive logic");
    // whole preset needs protect in the same write
    wr(`PPS_ADR_CMD, 32'hC);
    rdchk(`PPS_ADR_PDATA, {16'h0, pg[0]}, "unprotected preset");
    wr(`PPS_ADR_CMD, 32'h14);
    wait_idle();
    rdchk(`PPS_ADR_PDATA, 32'h0, "whole preset");
    play(32'h1, 80);
    cmp(2, 0, 80, "preset stream");
    // one flip per trigger in single mode, a rate of 1e-3 otherwise, none when off
    got.delete();
    wr(`PPS_ADR_CTRL, 32'h65);
    wait_bits(40);
    wr(`PPS_ADR_CMD, 32'h20);
    wait_bits(200);
    wr(`PPS_ADR_CTRL, 32'h61);
    repeat (30) @(posedge clk);
    chk(cnt(0, got.size()), 32'h1, "single error");
    play(32'h21, 3000);
    d = cnt(0, got.size());
    chk({31'h0, d >= 2 && d <= 4}, 32'h1, "error rate");
    play(32'h1, 200);
    chk(cnt(0, 200), 32'h0, "errors off");
    // zero run of 10 at the start of each 128-bit period
    wr(`PPS_ADR_CTRL, 32'h2);
    wr(`PPS_ADR_LEN, 32'hA);
    play(32'h2, 256);
    chk(cnt(0, 10) + cnt(128, 138), 32'h0, "zero run");
    chk({31'h0, cnt(0, 256) > 0}, 32'h1, "pseudorandom part");
    // pseudorandom mode repeats every 127 bits with 64 ones in each period
    play(32'h3, 254);
    d = 0;
    for (int i = 0; i < 127; i++) d += (got[i] !== got[i + 127]);
    chk(d, 0, "prbs period");
    chk(cnt(0, 127), 32'h40, "prbs ones");
    // A all ones twice, B all zeros three times
    wr(`PPS_ADR_CTRL, 32'h0);
    wr(`PPS_ADR_LEN, 32'h80);
    wr(`PPS_ADR_REPA, 32'h2);
    wr(`PPS_ADR_REPB, 32'h3);
    wr(`PPS_ADR_CMD, 32'h1C);
    wait_idle();
    wr(`PPS_ADR_CTRL, 32'h8);
    wr(`PPS_ADR_CMD, 32'h14);
    wait_idle();
    play(32'h0, 1280);
    cmp(1, 0, 1280, "two pattern order");
    // external select overrides the repeat counts
    @(posedge clk);
    ext <= 1'h1;
    play(32'h10, 512);
    cmp(2, 128, 512, "external b");
    chk({31'h0, pbl}, 32'h1, "b flag external");
    @(posedge clk);
    ext <= 1'h0;
    play(32'h10, 512);
    cmp(3, 128, 512, "external a");
    chk({31'h0, pbl}, 32'h0, "a flag external");
    report_and_stop();
  end
endmodule : test_programmable_pattern_sequencer
